// ===== pkg/umdl_params.svh
`ifndef UMDL_PARAMS_SVH
`define UMDL_PARAMS_SVH

// ********************************************************
// Register byte addresses
// ********************************************************
`define UMDL_ADDR_LINE_CTRL   32'h5000100C
`define UMDL_ADDR_MODEM_CTRL  32'h50001010
`define UMDL_ADDR_MODEM_STAT  32'h50001018
`define UMDL_ADDR_SCRATCH     32'h5000101C
`define UMDL_ADDR_LPDIV_LO    32'h50001020
`define UMDL_ADDR_LPDIV_HI    32'h50001024
`define UMDL_ADDR_IRQ_STAT    32'h50001100
`define UMDL_ADDR_IRQ_EN      32'h50001104
`define UMDL_ADDR_IRQ_CLR     32'h50001108

// ********************************************************
// Field positions
// ********************************************************
`define UMDL_MSR_DELTA_BIT    0
`define UMDL_MSR_STATUS_BIT   4
`define UMDL_MCR_RTS_BIT      1
`define UMDL_MCR_LOOP_BIT     4
`define UMDL_MCR_LPIR_BIT     6
`define UMDL_LCR_DIVISOR_LATCH_ACCESS_BIT_BIT     7
`define UMDL_IRQ_DELTA_BIT    0
`define UMDL_IRQ_PULSE_BIT    1

// ********************************************************
// Reset values and timing counts
// ********************************************************
`define UMDL_RST_BYTE         8'h00
`define UMDL_RST_DIV          16'h0000
`define UMDL_RST_IRQ          2'h0
`define UMDL_LP_PRESCALE      16

`endif

// ===== pkg/umdl_pkg.sv
// ********************************************************
// Shared types
// ********************************************************
package umdl_pkg;

    // Infrared pulse detector states, Gray coded along the path
    typedef enum logic [1:0] {
        UMDL_PD_IDLE = 2'h0,
        UMDL_PD_HIGH = 2'h1,
        UMDL_PD_HOLD = 2'h3
    } umdl_pd_state_e;

    // One register byte
    typedef logic [7:0] umdl_byte_t;

endpackage

// ===== verilog/umdl_lp_baud.sv
`timescale 1ns/1ps
`include "umdl_params.svh"

// ********************************************************
// Low-power baud tick generator
// ********************************************************
// One tick every PRESCALE * divisor clocks; held silent while
// the divisor is zero.
module umdl_lp_baud #(
    parameter int DIV_W = 16,
    parameter int PRE_W = 4
) (
    // Clock and reset
    input  wire logic             hclk,
    input  wire logic             hresetn,
    // Divisor from the register file
    input  wire logic [DIV_W-1:0] divisor,
    // Low-power baud tick
    output logic                  lp_tick_r
);

    localparam int CNT_W = DIV_W + PRE_W;

    logic [CNT_W-1:0] cnt_r;       // Down counter
    logic [DIV_W-1:0] div_seen_r;  // Divisor the count was loaded from
    logic [CNT_W-1:0] reload;      // 16 * divisor - 1
    logic             div_zero;    // Baud clock stopped

    assign div_zero = (divisor == '0);
    assign reload   = CNT_W'({divisor, {PRE_W{1'b0}}} - 1'b1);

    // Counter; restarts on any divisor change so a new rate
    // never waits out a stale long period
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_r      <= '0;
            div_seen_r <= '0;
            lp_tick_r  <= 1'b0;
        end else begin
            div_seen_r <= divisor;
            if (div_zero) begin
                cnt_r     <= '0;
                lp_tick_r <= 1'b0;
            end else if (divisor != div_seen_r) begin
                cnt_r     <= reload;
                lp_tick_r <= 1'b0;
            end else if (cnt_r == '0) begin
                cnt_r     <= reload;
                lp_tick_r <= 1'b1;
            end else begin
                cnt_r     <= cnt_r - 1'b1;
                lp_tick_r <= 1'b0;
            end
        end
    end

endmodule

// ===== verilog/umdl_top.sv
// Implementation choice: the AHB-Lite register port.
`timescale 1ns/1ps
`include "umdl_params.svh"

module umdl_top
    import umdl_pkg::*;
#(
    parameter int DIV_W = 16
) (
    // Clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic        hready,
    input  wire logic [31:0] hwdata,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // Modem handshake pins
    input  wire logic        cts_n,
    output logic             rts_n,
    // Infrared receive pin
    input  wire logic        sir_in,
    output logic             ir_pulse,
    // Interrupt
    output logic             irq
);

    // ********************************************************
    // Declarations
    // ********************************************************
    umdl_byte_t     line_ctrl_r;     // Line control, bit 7 opens divisor
    umdl_byte_t     modem_ctrl_r;    // Modem control
    umdl_byte_t     scratch_r;       // Software scratch byte
    umdl_byte_t     lpdiv_lo_r;      // Divisor bits 7:0
    umdl_byte_t     lpdiv_hi_r;      // Divisor bits 15:8
    logic           delta_r;         // Clear-to-send change flag
    logic           cts_prev_r;      // Status value last cycle
    logic [2:0]     cts_sync_r;      // Pin synchroniser
    logic           cts_level_r;     // Filtered, still active low
    logic [2:0]     sir_sync_r;      // Infrared pin synchroniser
    logic           sir_level_r;     // Filtered infrared level
    logic [1:0]     irq_stat_r;      // Sticky event bits
    logic [1:0]     irq_en_r;        // Event enables
    umdl_pd_state_e pd_state_r;      // Pulse detector state
    logic           pulse_r;         // Accepted pulse, one cycle
    logic           wr_pend_r;       // Write data phase pending
    logic [31:0]    wr_addr_r;       // Address of pending write
    logic [31:0]    rdata_r;         // Read data for data phase
    logic           irq_r;           // Interrupt level
    logic           rts_n_r;         // Request-to-send pin
    logic           lp_tick;         // Low-power baud tick
    logic           addr_ok;         // Valid address phase
    logic           rd_req;          // Read taken this edge
    logic           wr_now;          // Write data taken this edge
    logic           loop_on;         // Loopback active
    logic           divisor_latch_access_bit;            // Divisor latch access bit
    logic           cts_status;      // Clear-to-send status bit
    logic           delta_evt;       // Status changed this cycle
    logic           msr_read;        // Modem status read this edge
    logic [15:0]    lp_div;          // Combined divisor
    umdl_byte_t     wbyte;           // Write data low byte
    umdl_byte_t     rmux;            // Read mux

    assign addr_ok   = hsel & htrans[1] & hready;
    assign rd_req    = addr_ok & ~hwrite;
    assign wr_now    = wr_pend_r;
    assign wbyte     = hwdata[7:0];
    assign loop_on   = modem_ctrl_r[`UMDL_MCR_LOOP_BIT];
    assign divisor_latch_access_bit      = line_ctrl_r[`UMDL_LCR_DIVISOR_LATCH_ACCESS_BIT_BIT];
    assign lp_div    = {lpdiv_hi_r, lpdiv_lo_r};
    assign msr_read  = rd_req & (haddr == `UMDL_ADDR_MODEM_STAT);

    assign cts_status = loop_on ? modem_ctrl_r[`UMDL_MCR_RTS_BIT]
                                : ~cts_level_r;
    assign delta_evt  = (cts_status != cts_prev_r);

    // ********************************************************
    // Pin synchronisers
    // ********************************************************
    // Three stages; a level counts once stages two and three
    // agree, so a single metastable sample cannot glitch it
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cts_sync_r  <= 3'h7;
            cts_level_r <= 1'b1;
        end else begin
            cts_sync_r <= {cts_sync_r[1:0], cts_n};
            if (cts_sync_r[1] == cts_sync_r[2]) begin
                cts_level_r <= cts_sync_r[2];
            end
        end
    end

    // Infrared input, idle low
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sir_sync_r  <= 3'h0;
            sir_level_r <= 1'b0;
        end else begin
            sir_sync_r <= {sir_sync_r[1:0], sir_in};
            if (sir_sync_r[1] == sir_sync_r[2]) begin
                sir_level_r <= sir_sync_r[2];
            end
        end
    end

    // ********************************************************
    // Clear-to-send change tracking
    // ********************************************************
    // Previous status resets to deasserted, so an input held
    // low through reset looks like a change after release
    // Change seen after reset
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cts_prev_r <= 1'b0;
        end else begin
            cts_prev_r <= cts_status;
        end
    end

    // Change flag; a change in the read cycle wins over clear
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            delta_r <= 1'b0;
        end else if (delta_evt) begin
            delta_r <= 1'b1;
        end else if (msr_read) begin
            delta_r <= 1'b0;
        end
    end

    // ********************************************************
    // AHB-Lite bus interface
    // ********************************************************
    // Zero wait state: reads are muxed in the address phase and
    // registered, writes land at the end of the data phase.
    // A read straight after a write to the same word sees the
    // old value; the write takes effect on the same edge that registers the read data.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_r <= 1'b0;
            wr_addr_r <= 32'h00000000;
        end else if (hready) begin
            wr_pend_r <= addr_ok & hwrite;
            wr_addr_r <= haddr;
        end
    end

    // Read mux; unmapped and gated addresses read zero
    always_comb begin
        rmux = 8'h00;
        if (haddr == `UMDL_ADDR_LINE_CTRL) begin
            rmux = line_ctrl_r;
        end else if (haddr == `UMDL_ADDR_MODEM_CTRL) begin
            rmux = modem_ctrl_r;
        end else if (haddr == `UMDL_ADDR_MODEM_STAT) begin
            rmux = 8'h00;
            rmux[`UMDL_MSR_STATUS_BIT] = cts_status;
            rmux[`UMDL_MSR_DELTA_BIT]  = delta_r;
        end else if (haddr == `UMDL_ADDR_SCRATCH) begin
            rmux = scratch_r;
        end else if (haddr == `UMDL_ADDR_LPDIV_LO) begin
            rmux = divisor_latch_access_bit ? lpdiv_lo_r : 8'h00;
        end else if (haddr == `UMDL_ADDR_LPDIV_HI) begin
            rmux = divisor_latch_access_bit ? lpdiv_hi_r : 8'h00;
        end else if (haddr == `UMDL_ADDR_IRQ_STAT) begin
            rmux = {6'h00, irq_stat_r};
        end else if (haddr == `UMDL_ADDR_IRQ_EN) begin
            rmux = {6'h00, irq_en_r};
        end
    end

    // Registered read data
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rdata_r <= 32'h00000000;
        end else if (rd_req) begin
            rdata_r <= {24'h000000, rmux};
        end
    end

    // ********************************************************
    // Control registers
    // ********************************************************
    // Line and modem control
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            line_ctrl_r  <= `UMDL_RST_BYTE;
            modem_ctrl_r <= `UMDL_RST_BYTE;
        end else if (wr_now) begin
            if (wr_addr_r == `UMDL_ADDR_LINE_CTRL) begin
                line_ctrl_r <= wbyte;
            end else if (wr_addr_r == `UMDL_ADDR_MODEM_CTRL) begin
                modem_ctrl_r <= wbyte;
            end
        end
    end

    // Scratch byte; nothing else reads it
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            scratch_r <= `UMDL_RST_BYTE;
        end else if (wr_now && wr_addr_r == `UMDL_ADDR_SCRATCH) begin
            scratch_r <= wbyte;
        end
    end

    // Divisor bytes; writes without the latch bit are dropped
    // Both reset to zero, so the tick stays stopped until set
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            {lpdiv_hi_r, lpdiv_lo_r} <= `UMDL_RST_DIV;
        end else if (wr_now && divisor_latch_access_bit) begin
            if (wr_addr_r == `UMDL_ADDR_LPDIV_LO) begin
                lpdiv_lo_r <= wbyte;
            end else if (wr_addr_r == `UMDL_ADDR_LPDIV_HI) begin
                lpdiv_hi_r <= wbyte;
            end
        end
    end

    // ********************************************************
    // Low-power baud clock
    // ********************************************************
    umdl_lp_baud #(
        .DIV_W   (DIV_W),
        .PRE_W   (4)
    ) u_lp_baud (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .divisor   (DIV_W'(lp_div)),
        .lp_tick_r (lp_tick)
    );

    // ********************************************************
    // Infrared minimum-width pulse detector
    // ********************************************************
    // A high pulse is accepted only if a baud tick falls inside
    // it; shorter glitches drop back to idle. Tied to the tick,
    // so a zero divisor blocks every detection.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pd_state_r <= UMDL_PD_IDLE;
            pulse_r    <= 1'b0;
        end else begin
            pulse_r <= 1'b0;
            case (pd_state_r)
                // Wait for a rising edge in low-power mode
                UMDL_PD_IDLE: begin
                    if (sir_level_r &&
                        modem_ctrl_r[`UMDL_MCR_LPIR_BIT]) begin
                        pd_state_r <= UMDL_PD_HIGH;
                    end
                end
                UMDL_PD_HIGH: begin
                    if (!sir_level_r) begin
                        pd_state_r <= UMDL_PD_IDLE;
                    end else if (lp_tick) begin
                        pulse_r    <= 1'b1;
                        pd_state_r <= UMDL_PD_HOLD;
                    end
                end
                // Wait for the pulse to end
                UMDL_PD_HOLD: begin
                    if (!sir_level_r) begin
                        pd_state_r <= UMDL_PD_IDLE;
                    end
                end
                default: begin
                    pd_state_r <= UMDL_PD_IDLE;
                end
            endcase
        end
    end

    // ********************************************************
    // Interrupts
    // ********************************************************
    // Sticky bits; an event in the clear cycle wins
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_stat_r <= `UMDL_RST_IRQ;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if ((i == `UMDL_IRQ_DELTA_BIT && delta_evt) ||
                    (i == `UMDL_IRQ_PULSE_BIT && pulse_r)) begin
                    irq_stat_r[i] <= 1'b1;
                end else if (wr_now && wbyte[i] &&
                             wr_addr_r == `UMDL_ADDR_IRQ_CLR) begin
                    irq_stat_r[i] <= 1'b0;
                end
            end
        end
    end

    // Enable register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_en_r <= `UMDL_RST_IRQ;
        end else if (wr_now && wr_addr_r == `UMDL_ADDR_IRQ_EN) begin
            irq_en_r <= wbyte[1:0];
        end
    end

    // ********************************************************
    // Registered outputs
    // ********************************************************
    // Interrupt level lags status by one clock
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_r   <= 1'b0;
            rts_n_r <= 1'b1;
        end else begin
            irq_r   <= |(irq_stat_r & irq_en_r);
            // In loopback the pin is held deasserted
            rts_n_r <= loop_on | ~modem_ctrl_r[`UMDL_MCR_RTS_BIT];
        end
    end

    // Bus handshake: always ready, always OKAY
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    assign hrdata   = rdata_r;
    assign irq      = irq_r;
    assign rts_n    = rts_n_r;
    assign ir_pulse = pulse_r;

endmodule

// ===== verif/umdl_modem.sv
`timescale 1ns/1ps

// ****************************************
// Far side: modem handshake and IR sender
// ****************************************
module umdl_modem (
    // Clock
    input  wire logic hclk,
    // Lines driven into the block
    output logic      cts_n,
    output logic      sir_in
);
    // Idle: not clear to send, no light
    initial begin
        cts_n  = 1'b1;
        sir_in = 1'b0;
    end

    // Level change after a delay, so slow modems are covered
    task automatic set_cts(input logic lvl, input int dly);
        repeat (dly) @(posedge hclk);
        cts_n <= lvl;
    endtask

    // One light pulse of w clocks
    task automatic ir_burst(input int w);
        sir_in <= 1'b1;
        repeat (w) @(posedge hclk);
        sir_in <= 1'b0;
    endtask
endmodule

// ===== verif/umdl_top_chk.sv
`timescale 1ns/1ps
`include "umdl_params.svh"

// ****************************************
// Port checker
// ****************************************
module umdl_top_chk #(
    parameter int DIV_W = 16
) (
    // Clock and reset
    input wire logic        hclk,
    input wire logic        hresetn,
    // Bus
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [2:0]  hsize,
    input wire logic        hready,
    input wire logic [31:0] hwdata,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    // Pins
    input wire logic        cts_n,
    input wire logic        rts_n,
    input wire logic        sir_in,
    input wire logic        ir_pulse,
    input wire logic        irq
);
    logic        ap;       // Address phase taken
    logic        dw_r;     // Write data phase now
    logic [31:0] da_r;     // Its address
    logic        lat_r;    // Shadow latch access bit
    logic        lpb_r;    // Shadow loopback bit
    logic        rts_r;    // Shadow request-to-send bit
    logic [7:0]  scr_r;    // Shadow scratch
    logic [7:0]  lo_r;     // Shadow divisor low
    logic [7:0]  hi_r;     // Shadow divisor high
    logic [1:0]  en_r;     // Shadow interrupt enables
    logic [3:0]  zc_r;     // Clocks with zero divisor

    assign ap = hsel && htrans[1] && hready;

    // Shadows follow writes at the end of the data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dw_r  <= 1'b0;
            da_r  <= 32'h0;
            lat_r <= 1'b0;
            lpb_r <= 1'b0;
            rts_r <= 1'b0;
            scr_r <= 8'h00;
            lo_r  <= 8'h00;
            hi_r  <= 8'h00;
            en_r  <= 2'h0;
        end else begin
            dw_r <= ap && hwrite;
            da_r <= haddr;
            if (dw_r) begin
                case (da_r)
                    `UMDL_ADDR_LINE_CTRL: lat_r <= hwdata[7];
                    `UMDL_ADDR_MODEM_CTRL: begin
                        lpb_r <= hwdata[4];
                        rts_r <= hwdata[1];
                    end
                    `UMDL_ADDR_SCRATCH: scr_r <= hwdata[7:0];
                    `UMDL_ADDR_LPDIV_LO: if (lat_r) lo_r <= hwdata[7:0];
                    `UMDL_ADDR_LPDIV_HI: if (lat_r) hi_r <= hwdata[7:0];
                    `UMDL_ADDR_IRQ_EN: en_r <= hwdata[1:0];
                    default: ;
                endcase
            end
        end
    end

    // Zero divisor age; in-flight pulses get time to drain
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) zc_r <= 4'h0;
        else if ({hi_r, lo_r} != 16'h0000) zc_r <= 4'h0;
        else if (zc_r != 4'hF) zc_r <= zc_r + 4'h1;
    end

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    a_upper_zero: assert property (
        hrdata[31:8] == 24'h000000) else $error("upper bits set");
    a_scratch_read: assert property (
        ap && !hwrite && haddr == `UMDL_ADDR_SCRATCH
        |=> hrdata[7:0] == $past(scr_r)) else $error("scratch wrong");
    a_div_locked: assert property (
        ap && !hwrite && !lat_r && (haddr == `UMDL_ADDR_LPDIV_LO
        || haddr == `UMDL_ADDR_LPDIV_HI) |=> hrdata == 32'h0)
        else $error("divisor readable while locked");
    a_div_read: assert property (
        ap && !hwrite && lat_r && haddr == `UMDL_ADDR_LPDIV_HI
        |=> hrdata[7:0] == $past(hi_r)) else $error("divisor wrong");
    a_pulse_once: assert property (
        ir_pulse |=> !ir_pulse) else $error("pulse too long");
    a_zero_quiet: assert property (
        zc_r == 4'hF |-> !ir_pulse) else $error("pulse at zero");
    a_cts_change: assert property (
        $changed(cts_n) && !lpb_r && en_r[0] |-> ##[2:7] irq)
        else $error("no event on line change");
    a_loop_change: assert property (
        dw_r && da_r == `UMDL_ADDR_MODEM_CTRL && lpb_r && hwdata[4]
        && hwdata[1] != rts_r && en_r[0] |-> ##[1:5] irq)
        else $error("no event on loopback change");
    a_loop_status: assert property (
        ap && !hwrite && lpb_r && haddr == `UMDL_ADDR_MODEM_STAT
        |=> hrdata[4] == $past(rts_r)) else $error("loop status");

    c_pulse: cover property (ir_pulse);
    c_line: cover property ($fell(cts_n) && !lpb_r);
    c_loop: cover property (lpb_r && irq);
endmodule

bind umdl_top umdl_top_chk #(.DIV_W(DIV_W)) i_chk (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hready(hready), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .cts_n(cts_n),
    .rts_n(rts_n), .sir_in(sir_in), .ir_pulse(ir_pulse), .irq(irq));

// ===== verif/umdl_top_test.sv
`timescale 1ns/1ps
`include "umdl_params.svh"

module umdl_top_test;
    localparam logic [31:0] A_LC = `UMDL_ADDR_LINE_CTRL;
    localparam logic [31:0] A_MC = `UMDL_ADDR_MODEM_CTRL;
    localparam logic [31:0] A_MS = `UMDL_ADDR_MODEM_STAT;
    localparam logic [31:0] A_SC = `UMDL_ADDR_SCRATCH;
    localparam logic [31:0] A_LO = `UMDL_ADDR_LPDIV_LO;
    localparam logic [31:0] A_HI = `UMDL_ADDR_LPDIV_HI;
    localparam logic [31:0] A_IS = `UMDL_ADDR_IRQ_STAT;
    localparam logic [31:0] A_IE = `UMDL_ADDR_IRQ_EN;
    localparam logic [31:0] A_IC = `UMDL_ADDR_IRQ_CLR;

    logic        hclk, hresetn, hsel, hwrite;   // Bus controls
    logic [31:0] haddr, hwdata, rd;             // Address and data
    logic [1:0]  htrans;                        // Transfer type
    logic [2:0]  hsize;                         // Word size
    logic [31:0] hrdata;                        // Read data
    logic        hreadyout, hresp, cts_n;       // Slave answer, line
    logic        rts_n, sir_in, ir_pulse, irq;  // Pins
    wire logic   hready;                        // Single slave bus
    int          miscompares, n_tests, cyc;     // Counters

    assign hready = hreadyout;

    always #5 hclk = ~hclk;

    umdl_top i_dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hready(hready), .hwdata(hwdata), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .cts_n(cts_n),
        .rts_n(rts_n), .sir_in(sir_in), .ir_pulse(ir_pulse), .irq(irq));
    umdl_modem i_modem (.hclk(hclk), .cts_n(cts_n), .sir_in(sir_in));

    // Verdict and stop
    task automatic end_sim();
        $display("checks %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // A stuck slave would hang the bus tasks
    always @(posedge hclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            miscompares++;
            end_sim();
        end
    end

    // One word transfer; each phase held until hready is seen
    task automatic xfer(input logic w, input logic [31:0] a,
                        input logic [31:0] d);
        hsel   <= 1'b1;
        haddr  <= a;
        hwrite <= w;
        htrans <= 2'h2;
        do @(posedge hclk); while (hready !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hready !== 1'b1);
        rd = hrdata;
    endtask

    task automatic cmp(input logic [31:0] g, input logic [31:0] e);
        n_tests++;
        if (g !== e) begin
            miscompares++;
            $display("BAD %0t got %h exp %h", $time, g, e);
        end
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask

    // Read one register and compare
    task automatic chk(input logic [31:0] a, input logic [31:0] e);
        xfer(1'b0, a, 32'h0);
        cmp(rd, e);
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge hclk);
    endtask

    initial begin
        hclk = 1'b0; hresetn = 1'b0; hsel = 1'b0; hwrite = 1'b0;
        haddr = 32'h0; hwdata = 32'h0; htrans = 2'h0; hsize = 3'h2;
        miscompares = 0; n_tests = 0;
        idle(12);
        hresetn <= 1'b1;
        // Reset values, locked divisor, holes in the map
        chk(A_MS, 32'h0);
        chk(A_SC, 32'h0);
        wr(A_LO, 32'h33);
        wr(A_LC, 32'h80);
        chk(A_LO, 32'h0);
        chk(A_HI, 32'h0);
        chk(32'h50001014, 32'h0);
        chk(A_IC, 32'h0);
        cmp({31'h0, hresp}, 32'h0);
        $display("reset test done");
        // Scratch and divisor bytes; upper bits dropped
        wr(A_SC, 32'hFFFFFFA5);
        chk(A_SC, 32'hA5);
        wr(A_LO, 32'h1234);
        wr(A_HI, 32'h56);
        chk(A_LO, 32'h34);
        chk(A_HI, 32'h56);
        wr(A_LC, 32'h0);
        chk(A_HI, 32'h0);
        $display("register test done");
        // Line change flag, clear on read, interrupt mask
        wr(A_IE, 32'h3);
        i_modem.set_cts(1'b0, 3);
        idle(8);
        cmp({31'h0, irq}, 32'h1);
        chk(A_MS, 32'h11);
        chk(A_MS, 32'h10);
        chk(A_IS, 32'h1);
        i_modem.set_cts(1'b1, 0);
        idle(8);
        wr(A_IE, 32'h0);
        idle(2);
        cmp({31'h0, irq}, 32'h0);
        chk(A_MS, 32'h01);
        wr(A_IC, 32'h1);
        chk(A_IS, 32'h0);
        wr(A_IE, 32'h3);
        $display("line test done");
        // Loopback follows request-to-send, ignores the pin
        wr(A_MC, 32'h02);
        idle(2);
        cmp({31'h0, rts_n}, 32'h0);
        wr(A_MC, 32'h10);
        idle(6);
        chk(A_MS, 32'h00);
        wr(A_MC, 32'h12);
        idle(6);
        cmp({31'h0, rts_n}, 32'h1);
        chk(A_MS, 32'h11);
        i_modem.set_cts(1'b0, 0);
        idle(8);
        chk(A_MS, 32'h10);
        wr(A_MC, 32'h10);
        idle(6);
        chk(A_MS, 32'h01);
        wr(A_MC, 32'h0);
        i_modem.set_cts(1'b1, 0);
        idle(8);
        chk(A_MS, 32'h01);
        $display("loopback test done");
        // Infrared detection at divisor 54, then silence at 0
        wr(A_MC, 32'h40);
        wr(A_LC, 32'h80);
        wr(A_LO, 32'h36);
        wr(A_HI, 32'h00);
        idle(8);
        wr(A_IC, 32'h3);
        i_modem.ir_burst(880);
        idle(8);
        chk(A_IS, 32'h2);
        wr(A_LO, 32'h00);
        idle(8);
        wr(A_IC, 32'h3);
        i_modem.ir_burst(40);
        idle(8);
        chk(A_IS, 32'h0);
        $display("infrared test done");
        // Pin held asserted through a second reset
        i_modem.set_cts(1'b0, 0);
        idle(8);
        hresetn <= 1'b0;
        idle(12);
        hresetn <= 1'b1;
        idle(8);
        cmp({31'h0, irq}, 32'h0);
        chk(A_MS, 32'h11);
        $display("reset hold test done");
        end_sim();
    end
endmodule
